// >>> core/ufsic_top.sv
`timescale 1ns/100ps
`default_nettype none
module ufsic_top
	import ufsic_pkg::*;
#(
	parameter int FRAME_CYC = 160,
	parameter int IDLE_CHARS = 65536
) (
	// Clock and reset pin
	input wire logic core_clk,
	input wire logic rst_n,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Receiver word stream in, filtered stream to receive FIFO
	input wire logic rxWordValid,
	input wire logic [7:0] rxWord,
	output ufsic_rxw_t rxStore,
	// Transmitter start permission
	output logic txGo,
	// FIFO fill levels
	input wire logic [7:0] rxLevel,
	input wire logic [7:0] txLevel,
	// Interrupt sources
	input wire logic [5:0] lineCond,
	input wire logic breakEvt,
	input wire logic multiDropEvt,
	input wire logic txEmptyEvt,
	// Input pins watched for activity
	input wire logic [3:0] gpiIn,
	input wire logic rxPin,
	input wire logic ctsPin,
	// Clock control
	input wire logic clkStable,
	input wire logic extClkSel,
	output logic uartClkEn,
	output logic sleeping,
	// Interrupt pin
	output logic irq_n
);

	logic rstMeta_ff, rstSync_ff;
	logic [31:0] prdata_ff;
	logic pready_ff, pslverr_ff;
	logic [7:0] top_level_irq_enable_ff, isr_ff, stsEn_ff, sts_ff, first_mode_reg_ff;
	logic [7:0] trg_ff, flow_ff, divL_ff, divM_ff;
	logic [5:0] lsrEn_ff, spcEn_ff, spc_ff, lineCondPrev_ff;
	logic [7:0] ctlChar_ff [4];
	ufsic_rxw_t rxStore_ff, held_ff, replay_ff;
	ufsic_rxw_t nxt_rxStore, nxt_held, nxt_replay;
	logic heldOff_ff, nxt_heldOff, txHalt_ff, nxt_txHalt, txGo_ff;
	logic [3:0] gpiPrev_ff;
	logic rxPrev_ff, ctsPrev_ff, rxAt_ff, txAt_ff, rxEmp_ff, txEmp_ff;
	logic [31:0] charCyc_ff;
	logic [IDLE_W-1:0] idleCnt_ff;
	ufsic_pwr_t pwr_ff, nxt_pwr;
	logic uartClkEn_ff, sleeping_ff, irq_n_ff;
	logic [7:0] rdVal, nxt_isr, isrSet;
	logic [5:0] spcSet;
	logic [7:0] stsSet;
	logic rdHit, access, done, wr, rd, activity, charTick, idleDone;
	logic rxAt, txAt, rxEmp, txEmp, autoOk, sleepEntry, clkReadySet;
	logic [1:0] txMode;
	logic [31:0] charLen;

	// Register index match on an aligned word address
	function automatic logic addrIs(input logic [7:0] a,
		input logic [5:0] idx);
		return (a[1:0] == 2'h0) && (a[7:2] == idx);
	endfunction : addrIs

	// Reset pin released through two flops
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rstMeta_ff <= 1'b0;
			rstSync_ff <= 1'b0;
		end else begin
			rstMeta_ff <= 1'b1;
			rstSync_ff <= rstMeta_ff;
		end
	end

	assign access = psel && penable;
	assign done = access && pready_ff;
	assign wr = done && pwrite;
	assign rd = done && !pwrite;

	// Read data mux and address decode
	always_comb begin
		rdVal = 8'h00;
		rdHit = 1'b1;
		if (addrIs(paddr, IDX_TOP_LEVEL_IRQ_ENABLE)) rdVal = top_level_irq_enable_ff;
		else if (addrIs(paddr, IDX_ISR)) rdVal = isr_ff;
		else if (addrIs(paddr, IDX_LSREN)) rdVal = {2'h0, lsrEn_ff};
		else if (addrIs(paddr, IDX_LSR)) rdVal = {ctsPin, 1'b0, lineCond};
		else if (addrIs(paddr, IDX_SPCEN)) rdVal = {2'h0, spcEn_ff};
		else if (addrIs(paddr, IDX_SPC)) rdVal = {2'h0, spc_ff};
		else if (addrIs(paddr, IDX_STSEN)) rdVal = stsEn_ff;
		else if (addrIs(paddr, IDX_STS)) rdVal = sts_ff;
		else if (addrIs(paddr, IDX_FIRST_MODE_REG)) rdVal = first_mode_reg_ff;
		else if (addrIs(paddr, IDX_TRG)) rdVal = trg_ff;
		else if (addrIs(paddr, IDX_FLOW)) rdVal = flow_ff;
		else if (addrIs(paddr, IDX_RESUME_CHAR_FIRST)) rdVal = ctlChar_ff[0];
		else if (addrIs(paddr, IDX_RESUME_CHAR_FIRST + 6'h01)) rdVal = ctlChar_ff[1];
		else if (addrIs(paddr, IDX_RESUME_CHAR_FIRST + 6'h02)) rdVal = ctlChar_ff[2];
		else if (addrIs(paddr, IDX_RESUME_CHAR_FIRST + 6'h03)) rdVal = ctlChar_ff[3];
		else if (addrIs(paddr, IDX_DIVL)) rdVal = divL_ff;
		else if (addrIs(paddr, IDX_DIVM)) rdVal = divM_ff;
		else rdHit = 1'b0;
	end

	// APB answer: one wait state, data captured before completion
	always_ff @(posedge core_clk or negedge rstSync_ff) begin
		if (!rstSync_ff) begin
			pready_ff <= 1'b0;
			prdata_ff <= 32'h0000_0000;
			pslverr_ff <= 1'b0;
		end else begin
			pready_ff <= access && !pready_ff;
			if (access && !pready_ff) begin
				prdata_ff <= (pwrite || !rdHit) ? 32'h0000_0000
					: {24'h00_0000, rdVal};
				pslverr_ff <= !rdHit;
			end
		end
	end

	// Software-written configuration; all enables masked after reset
	always_ff @(posedge core_clk or negedge rstSync_ff) begin
		if (!rstSync_ff) begin
			top_level_irq_enable_ff <= 8'h00;
			lsrEn_ff <= 6'h00;
			spcEn_ff <= 6'h00;
			stsEn_ff <= 8'h00;
			first_mode_reg_ff <= 8'h00;
			trg_ff <= RST_TRG;
			flow_ff <= 8'h00;
			divL_ff <= RST_DIVL;
			divM_ff <= 8'h00;
		end else if (wr) begin
			if (addrIs(paddr, IDX_TOP_LEVEL_IRQ_ENABLE)) top_level_irq_enable_ff <= pwdata[7:0];
			if (addrIs(paddr, IDX_LSREN)) lsrEn_ff <= pwdata[5:0];
			if (addrIs(paddr, IDX_SPCEN)) spcEn_ff <= pwdata[5:0];
			if (addrIs(paddr, IDX_STSEN)) stsEn_ff <= pwdata[7:0] & STSEN_MASK;
			if (addrIs(paddr, IDX_FIRST_MODE_REG)) first_mode_reg_ff <= pwdata[7:0];
			if (addrIs(paddr, IDX_TRG)) trg_ff <= pwdata[7:0];
			if (addrIs(paddr, IDX_FLOW)) flow_ff <= pwdata[7:0];
			if (addrIs(paddr, IDX_DIVL)) divL_ff <= pwdata[7:0];
			if (addrIs(paddr, IDX_DIVM)) divM_ff <= pwdata[7:0];
		end
	end

	// Stop and resume characters
	always_ff @(posedge core_clk or negedge rstSync_ff) begin
		if (!rstSync_ff) begin
			for (int i = 0; i < 4; i++) begin
				ctlChar_ff[i] <= 8'h00;
			end
		end else begin
			for (int i = 0; i < 4; i++) begin
				if (wr && addrIs(paddr, IDX_RESUME_CHAR_FIRST + 6'(i))) begin
					ctlChar_ff[i] <= pwdata[7:0];
				end
			end
		end
	end

	// Transmit flow filter; index 0/1 resume, 2/3 stop
	assign txMode = flow_ff[FLOW_TX_LO +: 2];
	always_comb begin
		nxt_rxStore = replay_ff;
		nxt_replay = '0;
		nxt_held = held_ff;
		nxt_heldOff = heldOff_ff;
		nxt_txHalt = txHalt_ff;
		if (txMode == 2'h0) begin
			nxt_txHalt = 1'b0;
			nxt_held = '0;
			if (rxWordValid) nxt_rxStore = '{1'b1, rxWord};
		end else if (rxWordValid) begin
			if (txMode != 2'h3) begin
				if (rxWord == ctlChar_ff[{1'b1, txMode[1]}]) begin
					nxt_txHalt = 1'b1;
				end else if (rxWord == ctlChar_ff[{1'b0, txMode[1]}]) begin
					nxt_txHalt = 1'b0;
				end else begin
					nxt_rxStore = '{1'b1, rxWord};
				end
			end else if (held_ff.valid && heldOff_ff
				&& rxWord == ctlChar_ff[3]) begin
				nxt_txHalt = 1'b1;
				nxt_held = '0;
			end else if (held_ff.valid && !heldOff_ff
				&& rxWord == ctlChar_ff[1]) begin
				nxt_txHalt = 1'b0;
				nxt_held = '0;
			end else begin
				// A broken pair gives the held word back first
				if (held_ff.valid) nxt_rxStore = held_ff;
				nxt_held = '0;
				if (rxWord == ctlChar_ff[2] || rxWord == ctlChar_ff[0]) begin
					nxt_held = '{1'b1, rxWord};
					nxt_heldOff = rxWord == ctlChar_ff[2];
				end else if (held_ff.valid) begin
					nxt_replay = '{1'b1, rxWord};
				end else begin
					nxt_rxStore = '{1'b1, rxWord};
				end
			end
		end
	end

	// Flow filter state and transmitter gate
	always_ff @(posedge core_clk or negedge rstSync_ff) begin
		if (!rstSync_ff) begin
			rxStore_ff <= '0;
			replay_ff <= '0;
			held_ff <= '0;
			heldOff_ff <= 1'b0;
			txHalt_ff <= 1'b0;
			txGo_ff <= 1'b0;
		end else begin
			rxStore_ff <= nxt_rxStore;
			replay_ff <= nxt_replay;
			held_ff <= nxt_held;
			heldOff_ff <= nxt_heldOff;
			txHalt_ff <= nxt_txHalt;
			// Transmitter samples this only between words
			txGo_ff <= nxt_pwr == ST_AWAKE && !nxt_txHalt
				&& !first_mode_reg_ff[M1_TXDIS];
		end
	end

	// Level conditions for the top-level sources
	assign rxAt = trg_ff[7:4] != 4'h0
		&& rxLevel >= {1'b0, trg_ff[7:4], 3'h0};
	assign txAt = trg_ff[3:0] != 4'h0
		&& txLevel >= {1'b0, trg_ff[3:0], 3'h0};
	assign rxEmp = rxLevel == 8'h00;
	assign txEmp = txLevel == 8'h00;

	// Previous values for edge detection
	always_ff @(posedge core_clk or negedge rstSync_ff) begin
		if (!rstSync_ff) begin
			rxAt_ff <= 1'b0;
			txAt_ff <= 1'b0;
			rxEmp_ff <= 1'b1;
			txEmp_ff <= 1'b1;
			lineCondPrev_ff <= 6'h00;
			gpiPrev_ff <= 4'h0;
			rxPrev_ff <= 1'b1;
			ctsPrev_ff <= 1'b0;
		end else begin
			rxAt_ff <= rxAt;
			txAt_ff <= txAt;
			rxEmp_ff <= rxEmp;
			txEmp_ff <= txEmp;
			lineCondPrev_ff <= lineCond;
			gpiPrev_ff <= gpiIn;
			rxPrev_ff <= rxPin;
			ctsPrev_ff <= ctsPin;
		end
	end

	assign activity = gpiIn != gpiPrev_ff || rxPin != rxPrev_ff
		|| ctsPin != ctsPrev_ff;

	// Low-level events
	assign spcSet = {multiDropEvt, breakEvt, 4'h0};
	assign stsSet = {txEmptyEvt, sleepEntry, clkReadySet, 1'b0,
		gpiIn ^ gpiPrev_ff};

	// LSR, SPC and STS summary bits fire only on a new enabled low-level event
	always_comb begin
		isrSet = 8'h00;
		isrSet[ISR_LSR] = |(lineCond & ~lineCondPrev_ff & lsrEn_ff);
		isrSet[ISR_SPC] = |(spcSet & spcEn_ff);
		isrSet[ISR_STS] = |(stsSet & stsEn_ff);
		isrSet[ISR_RXTRG] = rxAt && !rxAt_ff;
		isrSet[ISR_TXTRG] = txAt && !txAt_ff;
		isrSet[ISR_TXEMP] = txEmp && !txEmp_ff;
		isrSet[ISR_RXEMP] = rxEmp && !rxEmp_ff;
		isrSet[ISR_CTS] = ctsPin != ctsPrev_ff;
		nxt_isr = isr_ff | isrSet;
		// Clear what was returned, only while pending; set wins
		if (rd && addrIs(paddr, IDX_ISR) && !irq_n_ff) begin
			nxt_isr = (isr_ff & ~prdata_ff[7:0]) | isrSet;
		end
	end

	// Top-level status and interrupt pin
	always_ff @(posedge core_clk or negedge rstSync_ff) begin
		if (!rstSync_ff) begin
			isr_ff <= RST_ISR;
			irq_n_ff <= 1'b1;
		end else begin
			isr_ff <= nxt_isr;
			irq_n_ff <= ~|(nxt_isr & top_level_irq_enable_ff);
		end
	end

	// Clear-on-read detail registers, set wins over the clear
	always_ff @(posedge core_clk or negedge rstSync_ff) begin
		if (!rstSync_ff) begin
			spc_ff <= 6'h00;
			sts_ff <= 8'h00;
		end else begin
			if (rd && addrIs(paddr, IDX_SPC)) begin
				spc_ff <= (spc_ff & ~prdata_ff[5:0]) | spcSet;
			end else begin
				spc_ff <= spc_ff | spcSet;
			end
			if (rd && addrIs(paddr, IDX_STS)) begin
				sts_ff <= (sts_ff & ~prdata_ff[7:0]) | stsSet;
			end else begin
				sts_ff <= sts_ff | stsSet;
			end
		end
	end

	// Character length from the programmed divisor
	assign charLen = 32'({divM_ff, divL_ff}) * 32'(FRAME_CYC);
	assign charTick = charCyc_ff + 32'h1 >= charLen;
	assign idleDone = 32'(idleCnt_ff) >= 32'(IDLE_CHARS);

	// Idle timing in character lengths
	always_ff @(posedge core_clk or negedge rstSync_ff) begin
		if (!rstSync_ff) begin
			charCyc_ff <= 32'h0000_0000;
			idleCnt_ff <= '0;
		end else if (activity) begin
			charCyc_ff <= 32'h0000_0000;
			idleCnt_ff <= '0;
		end else if (charTick) begin
			charCyc_ff <= 32'h0000_0000;
			if (!idleDone) idleCnt_ff <= idleCnt_ff + 1'b1;
		end else begin
			charCyc_ff <= charCyc_ff + 32'h1;
		end
	end

	assign autoOk = first_mode_reg_ff[M1_ASLEEP] && rxEmp && txEmp && irq_n_ff
		&& idleDone;

	// Power state machine
	always_comb begin
		nxt_pwr = pwr_ff;
		sleepEntry = 1'b0;
		clkReadySet = 1'b0;
		case (pwr_ff)
			ST_AWAKE: begin
				if (first_mode_reg_ff[M1_FSLEEP] || autoOk) begin
					nxt_pwr = ST_SLEEP;
					sleepEntry = 1'b1;
				end
			end
			ST_SLEEP: begin
				if (!first_mode_reg_ff[M1_FSLEEP] && (!first_mode_reg_ff[M1_ASLEEP]
					|| activity)) begin
					nxt_pwr = ST_WAKE;
				end
			end
			ST_WAKE: begin
				if (clkStable || extClkSel) begin
					nxt_pwr = ST_AWAKE;
					clkReadySet = 1'b1;
				end
			end
			default: nxt_pwr = ST_WAKE;
		endcase
	end

	// Power state and clock gating
	always_ff @(posedge core_clk or negedge rstSync_ff) begin
		if (!rstSync_ff) begin
			pwr_ff <= ST_WAKE;
			uartClkEn_ff <= 1'b0;
			sleeping_ff <= 1'b0;
		end else begin
			pwr_ff <= nxt_pwr;
			uartClkEn_ff <= nxt_pwr != ST_SLEEP;
			sleeping_ff <= nxt_pwr == ST_SLEEP;
		end
	end

	// Outputs
	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign rxStore = rxStore_ff;
	assign txGo = txGo_ff;
	assign uartClkEn = uartClkEn_ff;
	assign sleeping = sleeping_ff;
	assign irq_n = irq_n_ff;

endmodule : ufsic_top
`default_nettype wire

// >>> core/ufsic_pkg.sv
package ufsic_pkg;
	// Register indexes; byte address is four times the index
	localparam logic [5:0] IDX_TOP_LEVEL_IRQ_ENABLE = 6'h01;
	localparam logic [5:0] IDX_ISR = 6'h02;
	localparam logic [5:0] IDX_LSREN = 6'h03;
	localparam logic [5:0] IDX_LSR = 6'h04;
	localparam logic [5:0] IDX_SPCEN = 6'h05;
	localparam logic [5:0] IDX_SPC = 6'h06;
	localparam logic [5:0] IDX_STSEN = 6'h07;
	localparam logic [5:0] IDX_STS = 6'h08;
	localparam logic [5:0] IDX_FIRST_MODE_REG = 6'h09;
	localparam logic [5:0] IDX_TRG = 6'h10;
	localparam logic [5:0] IDX_FLOW = 6'h13;
	localparam logic [5:0] IDX_RESUME_CHAR_FIRST = 6'h14;
	localparam logic [5:0] IDX_DIVL = 6'h1C;
	localparam logic [5:0] IDX_DIVM = 6'h1D;
	// Values after reset, and the status-enable write mask
	localparam logic [7:0] RST_ISR = 8'h60;
	localparam logic [7:0] RST_TRG = 8'hFF;
	localparam logic [7:0] RST_DIVL = 8'h01;
	localparam logic [7:0] STSEN_MASK = 8'hEF;
	// Top-level status bit positions
	localparam int ISR_LSR = 0;
	localparam int ISR_SPC = 1;
	localparam int ISR_STS = 2;
	localparam int ISR_RXTRG = 3;
	localparam int ISR_TXTRG = 4;
	localparam int ISR_TXEMP = 5;
	localparam int ISR_RXEMP = 6;
	localparam int ISR_CTS = 7;
	// Mode bits
	localparam int M1_TXDIS = 1;
	localparam int M1_FSLEEP = 5;
	localparam int M1_ASLEEP = 6;
	// General-status bits
	localparam int STS_CLKRDY = 5;
	localparam int STS_SLEEP = 6;
	localparam int STS_TXEMP = 7;
	// Special-character bits
	localparam int SPC_BRK = 4;
	localparam int SPC_MDROP = 5;
	// Transmit flow field position, trigger scaling, idle counter width
	localparam int FLOW_TX_LO = 4;
	localparam int TRG_SHIFT = 3;
	localparam int IDLE_W = 17;
	// Power states
	typedef enum logic [1:0] {ST_AWAKE, ST_SLEEP, ST_WAKE} ufsic_pwr_t;
	// Received word as passed to the receive FIFO
	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} ufsic_rxw_t;
endpackage : ufsic_pkg

// >>> testbench/ufsic_host.sv
`timescale 1ns/100ps
`default_nettype none
module ufsic_host (
	// Clock
	input wire logic core_clk,
	// APB requester side
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [7:0] paddr,
	output logic [31:0] pwdata,
	// APB answer
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	// Idle bus at time zero
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
	end
	// Setup, then access held until pready is seen at an edge
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic e);
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		@(posedge core_clk);
		while (pready !== 1'b1) @(posedge core_clk);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		paddr <= ~a; // Released lines show no stale value
		pwdata <= ~d;
	endtask : xfer
endmodule : ufsic_host
`default_nettype wire

// >>> testbench/ufsic_top_properties.sv
`timescale 1ns/100ps
`default_nettype none
module ufsic_props
	import ufsic_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	// Data path and pins
	input wire logic rxWordValid,
	input wire logic [7:0] rxWord,
	input wire ufsic_rxw_t rxStore,
	input wire logic txGo,
	input wire logic [7:0] rxLevel,
	input wire logic [7:0] txLevel,
	input wire logic [3:0] gpiIn,
	input wire logic rxPin,
	input wire logic ctsPin,
	input wire logic uartClkEn,
	input wire logic sleeping,
	input wire logic irq_n
);
	logic done, wrDone, isrRd, forceWr, ctl, ctlHit, stopHit, autoSl, autoOk;
	logic top_level_irq_enable_ff;
	logic [1:0] flow_ff;
	logic [7:0] xon_ff, xoff_ff, mode_ff;
	logic [5:0] pins;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	// Decoded bus events and conditions
	assign done = psel && penable && pready;
	assign wrDone = done && pwrite;
	assign isrRd = done && !pwrite && paddr[7:2] == IDX_ISR;
	assign forceWr = wrDone && paddr[7:2] == IDX_FIRST_MODE_REG && pwdata[M1_FSLEEP];
	assign ctl = rxWordValid && flow_ff == 2'h1 && !sleeping;
	assign ctlHit = ctl && (rxWord == xon_ff || rxWord == xoff_ff);
	assign stopHit = ctl && rxWord == xoff_ff;
	assign autoSl = sleeping && mode_ff[M1_ASLEEP] && !mode_ff[M1_FSLEEP];
	assign autoOk = mode_ff[M1_ASLEEP] && rxLevel == 8'h00 && txLevel == 8'h00;
	assign pins = {gpiIn, rxPin, ctsPin};
	// Shadow of host settings
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			top_level_irq_enable_ff <= 1'b0;
			flow_ff <= 2'h0;
			xon_ff <= 8'h00;
			xoff_ff <= 8'h00;
			mode_ff <= 8'h00;
		end else if (wrDone) begin
			case (paddr[7:2])
				IDX_TOP_LEVEL_IRQ_ENABLE: top_level_irq_enable_ff <= top_level_irq_enable_ff | (|pwdata[7:0]);
				IDX_FLOW: flow_ff <= pwdata[FLOW_TX_LO +: 2];
				IDX_RESUME_CHAR_FIRST: xon_ff <= pwdata[7:0];
				IDX_RESUME_CHAR_FIRST + 6'h2: xoff_ff <= pwdata[7:0];
				IDX_FIRST_MODE_REG: mode_ff <= pwdata[7:0];
				default: ;
			endcase
		end
	end
	mask_reset_a: assert property (!irq_n |-> top_level_irq_enable_ff)
		else $error("interrupt pin low while all masked");
	ctl_drop_a: assert property (ctlHit |=> !rxStore.valid [*2])
		else $error("control character stored");
	stop_hold_a: assert property (stopHit |=> !txGo [*2])
		else $error("transmit not held after stop");
	sleep_clk_a: assert property (sleeping |-> !uartClkEn)
		else $error("clocks run in sleep");
	force_in_a: assert property (forceWr |-> ##[1:3] sleeping)
		else $error("force bit did not sleep");
	isr_clr_a: assert property (isrRd && !irq_n |=> irq_n)
		else $error("status read kept interrupt");
	pin_wake_a: assert property (
		autoSl && $changed(pins) |-> ##[1:4] !sleeping)
		else $error("no wake on pin activity");
	sleep_entry_a: assert property (
		$rose(sleeping) |-> $past(mode_ff[M1_FSLEEP] || (autoOk && irq_n)))
		else $error("sleep entered without cause");
endmodule : ufsic_props
bind ufsic_top ufsic_props chk_u (.*);
`default_nettype wire

// >>> testbench/ufsic_top_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module ufsic_top_tb_top;
	import ufsic_pkg::*;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic psel, penable, pwrite, pready, pslverr, e;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic rxWordValid = 1'b0;
	logic [7:0] rxWord = 8'h00;
	logic [7:0] rxLevel = 8'h00;
	logic [7:0] txLevel = 8'h00;
	logic [5:0] lineCond = 6'h00;
	logic breakEvt = 1'b0, multiDropEvt = 1'b0, txEmptyEvt = 1'b0;
	logic [3:0] gpiIn = 4'h0;
	logic rxPin = 1'b1, ctsPin = 1'b0, clkStable = 1'b1, extClkSel = 1'b0;
	ufsic_rxw_t rxStore;
	logic txGo, uartClkEn, sleeping, irq_n;
	logic [7:0] lastStore;
	int n_errors = 0;
	int checked = 0;
	int nStore = 0;
	// Clock and parts
	always #5 core_clk = ~core_clk;
	ufsic_top #(.FRAME_CYC(1), .IDLE_CHARS(2)) dut_u (.*);
	ufsic_host host_u (.*);
	// Words handed to the receive FIFO
	always @(posedge core_clk) begin
		if (rxStore.valid === 1'b1) begin
			nStore++;
			lastStore = rxStore.data;
		end
	end
	task automatic chk(input logic ok, input string m);
		checked++;
		if (ok !== 1'b1) begin
			n_errors++;
			$display("[ERR] %0t %s", $time, m);
		end
	endtask : chk
	task automatic wr(input logic [5:0] i, input logic [7:0] d);
		host_u.xfer(1'b1, {i, 2'h0}, {24'h0, d}, q, e);
	endtask : wr
	task automatic rd(input logic [5:0] i);
		host_u.xfer(1'b0, {i, 2'h0}, 32'h0, q, e);
	endtask : rd
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask : cyc
	// One received word, then count what reached the FIFO
	task automatic sendw(input logic [7:0] w, input int n, input string m);
		int base;
		base = nStore;
		@(posedge core_clk);
		rxWordValid <= 1'b1;
		rxWord <= w;
		@(posedge core_clk);
		rxWordValid <= 1'b0;
		rxWord <= ~w;
		cyc(4);
		chk(nStore - base == n, m);
		if (n > 0)
			chk(lastStore === w, m);
	endtask : sendw
	task automatic t_reset;
		q = 32'h0;
		repeat (20) if (q[7:0] !== RST_DIVL) rd(IDX_DIVL);
		chk(q[7:0] === RST_DIVL, "divisor reset");
		rd(IDX_ISR);
		chk(q[7:0] === RST_ISR && irq_n === 1'b1, "status reset");
		rd(IDX_TRG);
		chk(q[7:0] === RST_TRG, "trigger reset");
		rd(6'h3F);
		chk(e === 1'b1 && q === 32'h0, "unmapped");
		rd(IDX_STS);
		chk(q[STS_CLKRDY] === 1'b1 && uartClkEn === 1'b1, "clk ready");
	endtask : t_reset
	task automatic t_flow;
		wr(IDX_FIRST_MODE_REG, 8'h02);
		wr(IDX_RESUME_CHAR_FIRST, 8'h11);
		wr(IDX_RESUME_CHAR_FIRST + 6'h1, 8'h22);
		wr(IDX_RESUME_CHAR_FIRST + 6'h2, 8'h13);
		wr(IDX_RESUME_CHAR_FIRST + 6'h3, 8'h24);
		wr(IDX_FLOW, 8'h10);
		wr(IDX_FIRST_MODE_REG, 8'h00);
		cyc(2);
		chk(txGo === 1'b1, "tx allowed");
		sendw(8'h13, 0, "stop dropped");
		chk(txGo === 1'b0, "tx held");
		sendw(8'h41, 1, "rx goes on");
		sendw(8'h11, 0, "resume dropped");
		chk(txGo === 1'b1, "tx resumed");
		wr(IDX_FLOW, 8'h20);
		sendw(8'h24, 0, "stop2 dropped");
		chk(txGo === 1'b0, "tx held 2");
		sendw(8'h22, 0, "resume2 dropped");
		chk(txGo === 1'b1, "tx resumed 2");
		wr(IDX_FLOW, 8'h30);
		sendw(8'h13, 0, "first held");
		sendw(8'h55, 2, "pair broken");
		chk(txGo === 1'b1, "no stop");
		sendw(8'h13, 0, "first held");
		sendw(8'h24, 0, "pair stop");
		chk(txGo === 1'b0, "wide hold");
		rd(IDX_SPC);
		chk(q[3:0] === 4'h0, "no char irq");
		wr(IDX_FLOW, 8'h00);
	endtask : t_flow
	task automatic t_irq;
		wr(IDX_TRG, 8'h10);
		wr(IDX_TOP_LEVEL_IRQ_ENABLE, 8'h08);
		rxLevel <= 8'h07;
		cyc(3);
		chk(irq_n === 1'b1, "below trigger");
		rxLevel <= 8'h08;
		cyc(3);
		chk(irq_n === 1'b0, "trigger reached");
		rd(IDX_ISR);
		cyc(1);
		chk(q[ISR_RXTRG] === 1'b1 && irq_n === 1'b1, "read clears");
		rd(IDX_ISR);
		chk(q[ISR_RXTRG] === 1'b0, "cleared");
		wr(IDX_TOP_LEVEL_IRQ_ENABLE, 8'h05);
		wr(IDX_STSEN, 8'h80);
		wr(IDX_LSREN, 8'h01);
		txEmptyEvt <= 1'b1;
		cyc(1);
		txEmptyEvt <= 1'b0;
		cyc(3);
		chk(irq_n === 1'b0, "event pending");
		rd(IDX_ISR);
		cyc(1);
		chk(q[ISR_STS] === 1'b1 && irq_n === 1'b1, "summary");
		rd(IDX_STS);
		chk(q[STS_TXEMP] === 1'b1 && irq_n === 1'b1, "detail kept");
		rd(IDX_STS);
		chk(q[STS_TXEMP] === 1'b0, "detail read clears");
		lineCond <= 6'h01;
		cyc(3);
		rd(IDX_ISR);
		chk(q[ISR_LSR] === 1'b1, "line summary");
		rd(IDX_LSR);
		rd(IDX_LSR);
		chk(q[5:0] === 6'h01, "line kept");
		lineCond <= 6'h00;
		cyc(3);
		rd(IDX_LSR);
		chk(q[5:0] === 6'h00 && irq_n === 1'b1, "line gone");
		breakEvt <= 1'b1;
		multiDropEvt <= 1'b1;
		cyc(1);
		breakEvt <= 1'b0;
		multiDropEvt <= 1'b0;
		rd(IDX_SPC);
		chk(q[SPC_BRK] === 1'b1 && q[SPC_MDROP] === 1'b1, "special");
		rd(IDX_SPC);
		chk(q[5:0] === 6'h00, "special read clears");
		wr(IDX_TOP_LEVEL_IRQ_ENABLE, 8'h00);
		rxLevel <= 8'h00;
	endtask : t_irq
	task automatic t_sleep;
		wr(IDX_FIRST_MODE_REG, 8'h20);
		cyc(3);
		chk(sleeping === 1'b1 && uartClkEn === 1'b0, "forced");
		rd(IDX_DIVL);
		chk(q[7:0] === RST_DIVL, "bus alive");
		clkStable <= 1'b0;
		wr(IDX_FIRST_MODE_REG, 8'h00);
		cyc(4);
		chk(sleeping === 1'b0 && uartClkEn === 1'b1, "woken");
		rd(IDX_STS);
		chk(q[STS_CLKRDY] === 1'b0, "clk not ready");
		clkStable <= 1'b1;
		cyc(2);
		rd(IDX_STS);
		chk(q[STS_CLKRDY] === 1'b1, "clk ready again");
		txLevel <= 8'h01;
		wr(IDX_FIRST_MODE_REG, 8'h40);
		cyc(30);
		chk(sleeping === 1'b0, "fifo busy");
		txLevel <= 8'h00;
		repeat (30) if (sleeping !== 1'b1) @(posedge core_clk);
		chk(sleeping === 1'b1, "auto sleep");
		rxPin <= 1'b0;
		repeat (6) if (sleeping !== 1'b0) @(posedge core_clk);
		chk(sleeping === 1'b0, "rx wakes");
		repeat (30) if (sleeping !== 1'b1) @(posedge core_clk);
		gpiIn <= 4'h1;
		repeat (6) if (sleeping !== 1'b0) @(posedge core_clk);
		chk(sleeping === 1'b0, "gpi wakes");
		repeat (30) if (sleeping !== 1'b1) @(posedge core_clk);
		wr(IDX_FIRST_MODE_REG, 8'h00);
		cyc(4);
		chk(sleeping === 1'b0, "bit clear wakes");
	endtask : t_sleep
	task automatic t_shut;
		wr(IDX_FLOW, 8'h10);
		cyc(1);
		rst_n <= 1'b0;
		cyc(1);
		chk(irq_n === 1'b1 && txGo === 1'b0 && pready === 1'b0, "off");
		rst_n <= 1'b1;
		cyc(3);
		rd(IDX_FLOW);
		chk(q[7:0] === 8'h00, "settings lost");
	endtask : t_shut
	task automatic conclude;
		$display("checked %0d errors %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : conclude
	// Main sequence
	initial begin
		cyc(2);
		rst_n <= 1'b1;
		cyc(3);
		t_reset();
		t_flow();
		t_irq();
		t_sleep();
		t_shut();
		conclude();
	end
	// Hang guard
	initial begin
		#100000;
		n_errors++;
		$display("[ERR] %0t timeout", $time);
		conclude();
	end
endmodule : ufsic_top_tb_top
`default_nettype wire
